// file: include/tsi_pkg.sv
// Shared constants for the touch controller serial port, both ends.
// Assumes a 100 MHz system clock on each end; the bus clock comes from the host end.
package tsi_pkg;

  // Address layout
  localparam logic [4:0] ADDR_FIXED   = 5'h0F;
  localparam logic [1:0] STRAP_GND    = 2'h0;
  localparam logic [1:0] STRAP_VCC    = 2'h3;
  localparam logic [1:0] STRAP_SCL    = 2'h1;
  localparam logic [1:0] STRAP_SDA    = 2'h2;
  localparam logic       DIR_WRITE    = 1'h0;
  localparam logic       DIR_READ     = 1'h1;

  // Byte framing
  localparam logic [3:0] ACK_SLOT     = 4'h8;
  localparam logic [7:0] RELEASE_BYTE = 8'hFF;

  // Bus timing: one quarter of the bus clock period
  localparam int         CLK_NS       = 10;
  localparam int         QUARTER_NS   = 650;
  localparam int         QUARTER_CYC  = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);

endpackage

// file: include/tsi_bus_if.sv
// Two-wire bus between host end and device end.
// Data line is open drain with a pull-up; clock is driven by the host only.
`timescale 1ns/1ps
interface tsi_bus_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Pull-up wins unless an end pulls low
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// file: design/tsi_device.sv
// Device end: slave port into the register space of the touch controller.
// Bus pins arrive asynchronously; the user side is on clk_in.
`timescale 1ns/1ps
module tsi_device (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Bus
  tsi_bus_if.dev          bus,
  // Address strap, wired to ground, supply, clock or data
  input  wire logic       ad_strap_in,
  // Register side
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] wr_data_out,
  output logic            wr_stb_out,
  input  wire logic [7:0] rd_data_in
);

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_ADDR  = 9'h002,
    S_AACK  = 9'h004,
    S_REG   = 9'h008,
    S_RACK  = 9'h010,
    S_DATA  = 9'h020,
    S_DACK  = 9'h040,
    S_TX    = 9'h080,
    S_TACK  = 9'h100
  } dev_state_e;

  logic [2:0] scl_ff, sda_ff;
  logic [1:0] strap_ff;
  dev_state_e state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] cnt_ff, nxt_cnt;
  logic       rw_ff, nxt_rw;
  logic       mack_ff, nxt_mack;
  logic       oe_ff, nxt_oe;
  logic       dscl_ff, nxt_dscl;
  logic       dsda_ff, nxt_dsda;
  logic [7:0] raddr_ff, nxt_raddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic       stb_ff, nxt_stb;
  logic       rise, fall, start, stop, match;
  logic [1:0] low_bits;

  // Two-stage synchronisers, third stage only for edge finding
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_ff   <= 3'h7;
      sda_ff   <= 3'h7;
      strap_ff <= 2'h0;
    end else begin
      scl_ff   <= {scl_ff[1:0], bus.scl};
      sda_ff   <= {sda_ff[1:0], bus.sda};
      strap_ff <= {strap_ff[0], ad_strap_in};
    end
  end

  assign rise  = scl_ff[1] & ~scl_ff[2];
  assign fall  = ~scl_ff[1] & scl_ff[2];
  assign start = scl_ff[1] & scl_ff[2] & sda_ff[2] & ~sda_ff[1];
  assign stop  = scl_ff[1] & scl_ff[2] & ~sda_ff[2] & sda_ff[1];

  // strap follows clock, data, or stays fixed
  always_comb begin
    if (!dscl_ff && dsda_ff) begin
      low_bits = tsi_pkg::STRAP_SCL;
    end else if (!dsda_ff && dscl_ff) begin
      low_bits = tsi_pkg::STRAP_SDA;
    end else if (strap_ff[1]) begin
      low_bits = tsi_pkg::STRAP_VCC;
    end else begin
      low_bits = tsi_pkg::STRAP_GND;
    end
  end

  // fixed upper bits plus strap bits
  assign match = (shift_ff[7:1] == {tsi_pkg::ADDR_FIXED, low_bits});

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    nxt_rw    = rw_ff;
    nxt_mack  = mack_ff;
    nxt_oe    = oe_ff;
    nxt_raddr = raddr_ff;
    nxt_wdata = wdata_ff;
    nxt_stb   = 1'b0;
    // Flags learn how the strap is wired during each address byte
    nxt_dscl  = dscl_ff | (strap_ff[1] != scl_ff[1]);
    nxt_dsda  = dsda_ff | (strap_ff[1] != sda_ff[1]);
    if (start) begin
      nxt_state = S_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
      nxt_dscl  = 1'b0;
      nxt_dsda  = 1'b0;
    end else if (stop) begin
      nxt_state = S_IDLE;
      nxt_oe    = 1'b0;
    end else if (rise) begin
      case (state_ff)
        S_ADDR, S_REG, S_DATA: begin
          nxt_shift = {shift_ff[6:0], sda_ff[1]};
          nxt_cnt   = cnt_ff + 4'h1;
        end
        S_TACK: begin
          nxt_mack = ~sda_ff[1];
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (state_ff)
        S_ADDR: begin
          if (cnt_ff == tsi_pkg::ACK_SLOT) begin
            if (match) begin
              nxt_state = S_AACK;
              nxt_oe    = 1'b1;
              nxt_rw    = shift_ff[0];
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (rw_ff == tsi_pkg::DIR_READ) begin
            nxt_state = S_TX;
            nxt_shift = rd_data_in;
            nxt_oe    = ~rd_data_in[7];
            nxt_cnt   = 4'h1;
          end else begin
            nxt_state = S_REG;
            nxt_oe    = 1'b0;
            nxt_cnt   = 4'h0;
          end
        end
        S_REG: begin
          if (cnt_ff == tsi_pkg::ACK_SLOT) begin
            nxt_raddr = shift_ff;
            nxt_state = S_RACK;
            nxt_oe    = 1'b1;
          end
        end
        S_RACK, S_DACK: begin
          nxt_state = S_DATA;
          nxt_oe    = 1'b0;
          nxt_cnt   = 4'h0;
        end
        S_DATA: begin
          if (cnt_ff == tsi_pkg::ACK_SLOT) begin
            nxt_wdata = shift_ff;
            nxt_stb   = 1'b1;
            nxt_state = S_DACK;
            nxt_oe    = 1'b1;
          end
        end
        S_TX: begin
          if (cnt_ff == tsi_pkg::ACK_SLOT) begin
            nxt_oe    = 1'b0;
            nxt_state = S_TACK;
          end else begin
            nxt_oe    = ~shift_ff[6];
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_cnt   = cnt_ff + 4'h1;
          end
        end
        S_TACK: begin
          // Master ack asks for the same register again
          if (mack_ff) begin
            nxt_state = S_TX;
            nxt_shift = rd_data_in;
            nxt_oe    = ~rd_data_in[7];
            nxt_cnt   = 4'h1;
          end else begin
            nxt_state = S_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= S_IDLE;
      shift_ff <= 8'h00;
      cnt_ff   <= 4'h0;
      rw_ff    <= 1'b0;
      mack_ff  <= 1'b0;
      oe_ff    <= 1'b0;
      dscl_ff  <= 1'b0;
      dsda_ff  <= 1'b0;
      raddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      stb_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
      rw_ff    <= nxt_rw;
      mack_ff  <= nxt_mack;
      oe_ff    <= nxt_oe;
      dscl_ff  <= nxt_dscl;
      dsda_ff  <= nxt_dsda;
      raddr_ff <= nxt_raddr;
      wdata_ff <= nxt_wdata;
      stb_ff   <= nxt_stb;
    end
  end

  // Open drain: only ever pulls low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_ff;
  assign reg_addr_out   = raddr_ff;
  assign wr_data_out    = wdata_ff;
  assign wr_stb_out     = stb_ff;

endmodule

// file: design/tsi_host.sv
// Host end: bus master that writes or reads one register per command.
// Makes the bus clock from clk_in; no clock stretching by the device.
`timescale 1ns/1ps
module tsi_host (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Bus
  tsi_bus_if.host         bus,
  // Command
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_read_in,
  input  wire logic [6:0] cmd_dev_in,
  input  wire logic [7:0] cmd_reg_in,
  input  wire logic [7:0] cmd_wdata_in,
  output logic            cmd_ready_out,
  // Answer
  output logic            done_out,
  output logic            nack_out,
  output logic      [7:0] rdata_out
);

  typedef enum logic [5:0] {
    H_IDLE   = 6'h01,
    H_START  = 6'h02,
    H_BIT    = 6'h04,
    H_RSTART = 6'h08,
    H_STOP   = 6'h10,
    H_FREE   = 6'h20
  } host_state_e;

  logic [1:0]  sda_sync_ff;
  host_state_e state_ff, nxt_state;
  logic [7:0]  tick_ff, nxt_tick;
  logic [1:0]  ph_ff, nxt_ph;
  logic [3:0]  bit_ff, nxt_bit;
  logic [1:0]  idx_ff, nxt_idx;
  logic [7:0]  tx_ff, nxt_tx, rx_ff, nxt_rx;
  logic        scl_ff, nxt_scl, oe_ff, nxt_oe, bad_ff, nxt_bad;
  logic        rd_ff, nxt_rd, ready_ff, nxt_ready, done_ff, nxt_done;
  logic        nack_ff, nxt_nack;
  logic [6:0]  dev_ff, nxt_dev;
  logic [7:0]  reg_ff, nxt_reg, wd_ff, nxt_wd, rdata_ff, nxt_rdata;
  logic        tick;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end

  assign tick = (tick_ff == tsi_pkg::QUARTER_LAST);

  always_comb begin
    nxt_state = state_ff;
    nxt_tick  = (state_ff == H_IDLE || tick) ? 8'h00 : tick_ff + 8'h01;
    nxt_ph    = tick ? ph_ff + 2'h1 : ph_ff;
    nxt_bit   = bit_ff;
    nxt_idx   = idx_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_scl   = scl_ff;
    nxt_oe    = oe_ff;
    nxt_bad   = bad_ff;
    nxt_rd    = rd_ff;
    nxt_ready = ready_ff;
    nxt_done  = 1'b0;
    nxt_nack  = nack_ff;
    nxt_dev   = dev_ff;
    nxt_reg   = reg_ff;
    nxt_wd    = wd_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      H_IDLE: begin
        nxt_oe = 1'b0;
        nxt_ph = 2'h0;
        if (cmd_valid_in && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_rd    = cmd_read_in;
          nxt_dev   = cmd_dev_in;
          nxt_reg   = cmd_reg_in;
          nxt_wd    = cmd_wdata_in;
          nxt_nack  = 1'b0;
          nxt_state = H_START;
        end
      end
      H_START: begin
        if (tick && ph_ff == 2'h0) begin
          // pull data low with clock high
          nxt_oe = 1'b1;
        end else if (tick && ph_ff == 2'h1) begin
          nxt_scl   = 1'b0;
          nxt_ph    = 2'h0;
          nxt_bit   = 4'h0;
          nxt_idx   = 2'h0;
          nxt_tx    = {dev_ff, tsi_pkg::DIR_WRITE};
          nxt_state = H_BIT;
        end
      end
      H_RSTART: begin
        if (tick) begin
          case (ph_ff)
            2'h0: nxt_oe  = 1'b0;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe  = 1'b1;
            default: begin
              nxt_scl   = 1'b0;
              nxt_bit   = 4'h0;
              nxt_idx   = 2'h2;
              nxt_tx    = {dev_ff, tsi_pkg::DIR_READ};
              nxt_state = H_BIT;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          case (ph_ff)
            // data changes only while clock low
            2'h0: nxt_oe  = (bit_ff != tsi_pkg::ACK_SLOT) & ~tx_ff[7];
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (bit_ff != tsi_pkg::ACK_SLOT) begin
                nxt_rx = {rx_ff[6:0], sda_sync_ff[1]};
              end else begin
                nxt_bad = sda_sync_ff[1];
              end
            end
            default: begin
              nxt_scl = 1'b0;
              if (bit_ff != tsi_pkg::ACK_SLOT) begin
                nxt_tx  = {tx_ff[6:0], 1'b1};
                nxt_bit = bit_ff + 4'h1;
              end else begin
                nxt_bit = 4'h0;
                if (idx_ff != 2'h3 && bad_ff) begin
                  nxt_nack  = 1'b1;
                  nxt_state = H_STOP;
                end else begin
                  case (idx_ff)
                    2'h0: begin
                      nxt_idx = 2'h1;
                      nxt_tx  = reg_ff;
                    end
                    2'h1: begin
                      nxt_idx   = 2'h2;
                      nxt_tx    = wd_ff;
                      nxt_state = rd_ff ? H_RSTART : H_BIT;
                    end
                    2'h2: begin
                      nxt_idx   = 2'h3;
                      nxt_tx    = tsi_pkg::RELEASE_BYTE;
                      nxt_state = rd_ff ? H_BIT : H_STOP;
                    end
                    default: begin
                      // no ack on read byte, then stop
                      nxt_rdata = rx_ff;
                      nxt_state = H_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (ph_ff)
            2'h0: nxt_oe  = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe  = 1'b0;
            default: nxt_state = H_FREE;
          endcase
        end
      end
      H_FREE: begin
        // Two quarters of bus free time before the next start
        if (tick && ph_ff == 2'h1) begin
          nxt_done  = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = H_IDLE;
        end
      end
      default: nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= H_IDLE;
      tick_ff  <= 8'h00;
      ph_ff    <= 2'h0;
      bit_ff   <= 4'h0;
      idx_ff   <= 2'h0;
      tx_ff    <= 8'h00;
      rx_ff    <= 8'h00;
      scl_ff   <= 1'b1;
      oe_ff    <= 1'b0;
      bad_ff   <= 1'b0;
      rd_ff    <= 1'b0;
      ready_ff <= 1'b1;
      done_ff  <= 1'b0;
      nack_ff  <= 1'b0;
      dev_ff   <= 7'h00;
      reg_ff   <= 8'h00;
      wd_ff    <= 8'h00;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tick_ff  <= nxt_tick;
      ph_ff    <= nxt_ph;
      bit_ff   <= nxt_bit;
      idx_ff   <= nxt_idx;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
      scl_ff   <= nxt_scl;
      oe_ff    <= nxt_oe;
      bad_ff   <= nxt_bad;
      rd_ff    <= nxt_rd;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
      nack_ff  <= nxt_nack;
      dev_ff   <= nxt_dev;
      reg_ff   <= nxt_reg;
      wd_ff    <= nxt_wd;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus.scl         = scl_ff;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = oe_ff;
  assign cmd_ready_out   = ready_ff;
  assign done_out        = done_ff;
  assign nack_out        = nack_ff;
  assign rdata_out       = rdata_ff;

endmodule

// file: test/tsi_bus_assertions.sv
// Checker for the two-wire bus between the host end and the device end.
// Assumes both ends run on clk_in and share one active-low reset.
`timescale 1ns/1ps
module tsi_bus_assertions (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // Bus signals
  input  wire logic scl,
  input  wire logic host_sda_o,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_o,
  input  wire logic dev_sda_oe,
  input  wire logic sda
);
  // Minimum phases in clk_in cycles; 32 bits so no wrap within a run
  localparam logic [31:0] LOW_MIN   = 32'h0000_0082;
  localparam logic [31:0] HIGH_MIN  = 32'h0000_0046;
  localparam logic [31:0] SETUP_MIN = 32'h0000_003C;
  // Longest legal low with clock high: a zero bit or ack over a whole high phase
  localparam logic [31:0] HOLD_MAX  = 32'h0000_0083;

  logic [31:0] hi_cnt_ff;
  logic [31:0] lo_cnt_ff;
  logic [31:0] sda_hi_cnt_ff;
  logic [31:0] hold_cnt_ff;

  // Run lengths of line levels
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hi_cnt_ff     <= 32'h0000_0000;
      lo_cnt_ff     <= 32'h0000_0000;
      sda_hi_cnt_ff <= 32'h0000_0000;
      hold_cnt_ff   <= 32'h0000_0000;
    end else begin
      hi_cnt_ff     <= scl ? hi_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
      lo_cnt_ff     <= scl ? 32'h0000_0000 : lo_cnt_ff + 32'h0000_0001;
      sda_hi_cnt_ff <= sda ? sda_hi_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
      hold_cnt_ff   <= (scl && !sda) ? hold_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_dev_data_stable: assert property (
    (scl && $past(scl)) |-> $stable(dev_sda_oe)) else $error("device data moved, clock high");
  a_dev_open_drain: assert property (
    dev_sda_oe |-> !dev_sda_o) else $error("device drives data high");
  a_host_open_drain: assert property (
    host_sda_oe |-> !host_sda_o) else $error("host drives data high");
  a_scl_low_min: assert property (
    $rose(scl) |-> lo_cnt_ff >= LOW_MIN) else $error("clock low phase too short");
  a_scl_high_min: assert property (
    $fell(scl) |-> hi_cnt_ff >= HIGH_MIN) else $error("clock high phase too short");
  a_start_setup: assert property (
    (scl && $fell(sda)) |-> sda_hi_cnt_ff >= SETUP_MIN) else $error("start setup too short");
  a_stop_bus_free: assert property (
    (scl && $rose(sda)) |=> (scl && sda) [*8]) else $error("bus not free after stop");
  a_stop_dev_quiet: assert property (
    (scl && $rose(sda)) |=> !dev_sda_oe [*8]) else $error("device drives after stop");
  a_idle_not_held: assert property (
    (scl && !sda) |-> hold_cnt_ff < HOLD_MAX) else $error("data held low, clock high");
endmodule

// file: test/touch_ctrl_i2c_slave_port_tb.sv
// Bench: host end and device end joined on one bus, user sides driven here.
// Assumes the package, bus interface and both ends are compiled first.
`timescale 1ns/1ps
module touch_ctrl_i2c_slave_port_tb;
  logic        clk_in;
  logic        reset_n_in;
  logic        cmd_valid;
  logic        cmd_read;
  logic [6:0]  cmd_dev;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_wdata;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [7:0]  rdata;
  logic [7:0]  reg_addr;
  logic [7:0]  wr_data;
  logic        wr_stb;
  logic [7:0]  rd_data;
  logic [1:0]  strap_sel;
  logic        ad_strap;
  logic [7:0]  dev_mem [256];
  logic [7:0]  exp_mem [256];
  logic [7:0]  rg [4];
  logic [15:0] exp_wr_q [$];
  logic [8:0]  exp_done_q [$];
  logic [8:0]  exp_addr_q [$];
  logic [7:0]  last_rdata;
  logic [8:0]  shift;
  logic        prev_scl;
  logic        prev_sda;
  int          num_errors;
  int          compares;
  int          cycles;
  int          bit_cnt;
  int          seed;

  tsi_bus_if bus ();

  // Strap pin wired to ground, supply, clock or data
  assign ad_strap = (strap_sel == tsi_pkg::STRAP_GND) ? 1'b0 :
                    (strap_sel == tsi_pkg::STRAP_VCC) ? 1'b1 :
                    (strap_sel == tsi_pkg::STRAP_SCL) ? bus.scl : bus.sda;
  assign rd_data = dev_mem[reg_addr];

  tsi_host i_tsi_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus(bus),
    .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_dev_in(cmd_dev),
    .cmd_reg_in(cmd_reg), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready),
    .done_out(done), .nack_out(nack), .rdata_out(rdata));
  tsi_device i_tsi_device (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus(bus),
    .ad_strap_in(ad_strap), .reg_addr_out(reg_addr), .wr_data_out(wr_data),
    .wr_stb_out(wr_stb), .rd_data_in(rd_data));
  tsi_bus_assertions i_tsi_bus_assertions (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .scl(bus.scl), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_wr(input logic [15:0] got);
    report(got, exp_wr_q.size() > 0 ? exp_wr_q.pop_front() : 'x);
  endtask

  task automatic cmp_done(input logic [8:0] got);
    report({7'h00, got}, {7'h00, exp_done_q.size() > 0 ? exp_done_q.pop_front() : 9'bx});
  endtask

  task automatic cmp_addr(input logic [8:0] got);
    report({7'h00, got}, {7'h00, exp_addr_q.size() > 0 ? exp_addr_q.pop_front() : 9'bx});
  endtask

  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One command; expected results are noted before it starts
  task automatic run_cmd(input logic [1:0] st, input logic rd, input logic [6:0] dev,
                         input logic [7:0] rgn, input logic [7:0] wd);
    logic hit;
    int   n;
    hit = (dev == {tsi_pkg::ADDR_FIXED, st});
    exp_addr_q.push_back({dev, tsi_pkg::DIR_WRITE, ~hit});
    if (hit && rd) exp_addr_q.push_back({dev, tsi_pkg::DIR_READ, 1'b0});
    if (hit && !rd) begin
      exp_wr_q.push_back({rgn, wd});
      exp_mem[rgn] = wd;
    end
    if (hit && rd) last_rdata = exp_mem[rgn];
    exp_done_q.push_back({~hit, last_rdata});
    @(posedge clk_in);
    #1;
    strap_sel = st;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_reg = rgn;
    cmd_wdata = wd;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (done !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, done, 1'b1);
    end
  endtask

  // Result watcher and wire watcher
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
    if (reset_n_in === 1'b1) begin
      if (wr_stb === 1'b1) begin
        cmp_wr({reg_addr, wr_data});
        dev_mem[reg_addr] = wr_data;
      end
      if (done === 1'b1) cmp_done({nack, rdata});
      if (bus.scl === 1'b1 && prev_scl === 1'b1 && prev_sda === 1'b1 && bus.sda === 1'b0) begin
        bit_cnt = 0;
      end else if (bus.scl === 1'b1 && prev_scl === 1'b0 && bit_cnt < 9) begin
        shift = {shift[7:0], bus.sda};
        bit_cnt++;
        if (bit_cnt == 9) cmp_addr(shift);
      end
    end
    prev_scl = bus.scl;
    prev_sda = bus.sda;
  end

  initial begin
    seed = 32'h0000_838d;
    reset_n_in = 1'b0;
    {cmd_valid, cmd_read, cmd_dev, cmd_reg, cmd_wdata} = '0;
    strap_sel = 2'h0;
    {num_errors, compares, cycles} = '0;
    bit_cnt = 9;
    shift = 9'h000;
    {prev_scl, prev_sda} = 2'b11;
    last_rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      dev_mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (12) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    for (int s = 0; s < 4; s++) begin
      rg[s] = 8'($random(seed));
      run_cmd(2'(s), 1'b0, {tsi_pkg::ADDR_FIXED, 2'(s)}, rg[s], 8'($random(seed)));
    end
    // wrong strap bits, then wrong fixed bits
    run_cmd(2'h3, 1'b0, {tsi_pkg::ADDR_FIXED, 2'h0}, rg[1], 8'($random(seed)));
    run_cmd(2'h3, 1'b0, {5'h0E, 2'h3}, rg[2], 8'($random(seed)));
    run_cmd(2'h3, 1'b1, {tsi_pkg::ADDR_FIXED, 2'h3}, rg[3], 8'h00);
    run_cmd(2'h3, 1'b1, {tsi_pkg::ADDR_FIXED, 2'h3}, rg[0], 8'h00);
    repeat (20) @(posedge clk_in);
    if (exp_wr_q.size() + exp_done_q.size() + exp_addr_q.size() != 0) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, exp_done_q.size(), 0);
    end
    test_done();
  end
endmodule
